// >>> rtl/dprc_params.svh
`ifndef DPRC_PARAMS_SVH
`define DPRC_PARAMS_SVH
// timing
`define DPRC_CLK_MHZ 100
`define DPRC_RTC_FIRST_US 16000
`define DPRC_RTC_P60_US 16667
`define DPRC_RTC_P50_US 20000
`define DPRC_RTC_W 24
// apb byte offsets
`define DPRC_OFF_CMD 8'h00
`define DPRC_OFF_DATA 8'h04
`define DPRC_OFF_ANSWER 8'h08
`define DPRC_OFF_RESULT 8'h0C
`define DPRC_OFF_ISTAT 8'h10
`define DPRC_OFF_CONFIG 8'h14
`define DPRC_OFF_BEAM 8'h18
// field positions
`define DPRC_CMD_ARG_LSB 8
`define DPRC_ANS_REPLY 0
`define DPRC_ANS_REJECT 1
`define DPRC_ANS_RUN 2
`define DPRC_CFG_LINE50 0
`define DPRC_IST_EOF 0
`define DPRC_IST_PF1 1
`define DPRC_IST_RTC 2
`define DPRC_IEN_EOF 0
`define DPRC_IEN_PF1 1
`define DPRC_IEN_RTC_MASK 16'h1100
`define DPRC_INS_OP_LSB 12
`define DPRC_INS_SIZE 8
`define DPRC_PROT_BIT 16
// character drawing
`define DPRC_CHAR_EXIT 8'h00
`define DPRC_SPACE_A 16'h0008
`define DPRC_SPACE_B 16'h000C
`endif

// >>> rtl/dprc_pkg.sv
`include "dprc_params.svh"
package dprc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_EXEC = 5'h04,
    ST_SPACE = 5'h08,
    ST_CHAR = 5'h10
  } dprc_state_type;
  typedef enum logic [4:0] {
    C_RESET = 5'h00, C_LD_IEN = 5'h01, C_LD_IDIS = 5'h02,
    C_UL_IEN = 5'h03, C_LD_P = 5'h04, C_UL_P = 5'h05,
    C_LD_BASE = 5'h06, C_UL_BASE = 5'h07, C_START = 5'h08,
    C_FINISH = 5'h09, C_LD_SCR = 5'h0A, C_UL_SCR = 5'h0B,
    C_LD_WLIM = 5'h0C, C_LD_MEM = 5'h0D, C_UL_MEM = 5'h0E,
    C_SET_PROT = 5'h0F, C_CLR_ISTAT = 5'h10
  } dprc_cmd_type;
  typedef enum logic [3:0] {
    OP_CTRL = 4'h0, OP_EOF = 4'h1, OP_LDP = 4'h2, OP_ULP = 4'h3,
    OP_EXEC = 4'h4, OP_CHRF = 4'h5, OP_CHRV = 4'h6
  } dprc_op_type;
  typedef struct packed {
    dprc_state_type st;
    logic busy;
    logic [7:0] p;
    logic [7:0] base;
    logic [15:0] ien;
    logic [7:0] wlo;
    logic [7:0] whi;
    logic [15:0][15:0] scr;
    logic [15:0] data;
    logic [15:0] result;
    logic reply;
    logic reject;
    logic [2:0] istat;
    logic line50;
    logic [15:0] ir;
    logic xmode;
    logic stopreq;
    logic chvar;
    logic chsize;
    logic [7:0] spx;
    logic [7:0] spy;
    logic [15:0] bx;
    logic [15:0] by;
    logic [`DPRC_RTC_W-1:0] rtc_cnt;
    logic rtc_on;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic char_stb;
    logic [7:0] char_code;
  } dprc_regs_type;
endpackage

// >>> rtl/dprc_display_processor.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dprc_params.svh"
// Operation
// [R1] reset command replies, clears interrupt enable
// [R2] idle enable load replies, reads back
// [R3] clock bits in enable start clock interrupt
// [R4] stopped: load/unload program pointer, reply
// [R5] stopped: load/unload section base, reply
// [R6] execute fetches indirect; control word exits
// [R7] start replies, runs from program pointer
// [R8] running: scratchpad load/unload rejected
// [R9] after reset scratchpad unload replies again
// [R10] running: enable/disable loads rejected
// [R11] finish replies, ends instruction, then halts
// [R12] end of frame raises enabled interrupt
// [R13] write outside limits raises program failure
// [R14] write to protected word raises failure
// [R15] blocked write leaves memory unchanged
// [R16] first clock interrupt within 17 ms
// [R17] clock interrupt period per line frequency
// [R18] reset command clears pending clock interrupt
// [R19] fixed spacing characters, size, exit symbol
// [R20] variable spacing advance, exit symbol
// [R21] one answer per command; host waits
module dprc_display_processor
  import dprc_pkg::*;
#(
  parameter int unsigned RTC_FIRST_CYC =
    `DPRC_RTC_FIRST_US * `DPRC_CLK_MHZ,
  parameter int unsigned RTC_P60_CYC = `DPRC_RTC_P60_US * `DPRC_CLK_MHZ,
  parameter int unsigned RTC_P50_CYC = `DPRC_RTC_P50_US * `DPRC_CLK_MHZ
)(
  input wire logic sys_clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic pready_o, // apb ready
  output logic [31:0] prdata_o, // apb read data
  output logic pslverr_o, // apb error, unmapped
  output logic int_o, // any interrupt pending
  output logic running_o, // processor running
  output logic char_stb_o, // character drawn pulse
  output logic [7:0] char_code_o // character code
);
  localparam int unsigned RTC_MAX = 2 ** `DPRC_RTC_W;

  if (RTC_FIRST_CYC == 0 || RTC_P60_CYC < 2 || RTC_P50_CYC < 2 ||
      RTC_FIRST_CYC >= RTC_MAX || RTC_P60_CYC >= RTC_MAX ||
      RTC_P50_CYC >= RTC_MAX)
  begin : g_chk
    $error("dprc: clock interrupt counts out of range");
  end

  function automatic logic [7:0] eff(input logic [7:0] b,
                                     input logic [7:0] off);
    eff = 8'(b + off);
  endfunction

  dprc_regs_type q;
  dprc_regs_type n;
  logic [16:0] mem [256];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [16:0] mem_wd;
  logic [2:0] ist_set;
  logic [2:0] ist_clr;
  logic acc;
  logic cmd_take;
  logic rej;
  logic rtc_en;
  logic dev_viol;
  logic [7:0] arg;
  logic [16:0] word;
  logic [15:0] adv;
  dprc_cmd_type cmd;

  assign acc = psel_i && penable_i && q.pready;
  assign cmd_take = acc && pwrite_i && paddr_i == `DPRC_OFF_CMD;
  assign cmd = dprc_cmd_type'(pwdata_i[4:0]);
  assign arg = pwdata_i[`DPRC_CMD_ARG_LSB +: 8];
  assign rtc_en = (q.ien & `DPRC_IEN_RTC_MASK) == `DPRC_IEN_RTC_MASK;

  always_comb
  begin
    n = q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    ist_set = '0;
    ist_clr = '0;
    rej = 1'b0;
    dev_viol = 1'b0;
    word = '0;
    adv = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.char_stb = 1'b0;
    // read data is prepared in setup so the access needs no wait
    if (psel_i && !penable_i)
    begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr_i)
        `DPRC_OFF_CMD: ;
        `DPRC_OFF_DATA: n.prdata[15:0] = q.data;
        `DPRC_OFF_ANSWER:
        begin
          n.prdata[`DPRC_ANS_REPLY] = q.reply;
          n.prdata[`DPRC_ANS_REJECT] = q.reject;
          n.prdata[`DPRC_ANS_RUN] = q.busy;
        end
        `DPRC_OFF_RESULT: n.prdata[15:0] = q.result;
        `DPRC_OFF_ISTAT: n.prdata[2:0] = q.istat;
        `DPRC_OFF_CONFIG: n.prdata[`DPRC_CFG_LINE50] = q.line50;
        `DPRC_OFF_BEAM: n.prdata = {q.by, q.bx};
        default: n.pslverr = 1'b1;
      endcase
    end
    // instruction engine
    case (q.st)
      ST_IDLE: ;
      ST_FETCH:
      begin
        if (q.stopreq)
        begin
          n.st = ST_IDLE; // see [R11]
          n.stopreq = 1'b0;
        end
        else
        begin
          n.ir = mem[eff(q.base, q.p)][15:0]; // see [R7]
          n.p = 8'(q.p + 8'h01);
          n.st = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        n.st = ST_FETCH;
        n.xmode = 1'b0;
        case (dprc_op_type'(q.ir[`DPRC_INS_OP_LSB +: 4]))
          OP_CTRL: ; // in execute mode: immediate exit, see [R6]
          OP_EOF:
            if (q.ien[`DPRC_IEN_EOF])
              ist_set[`DPRC_IST_EOF] = 1'b1; // see [R12]
          OP_LDP: n.p = q.ir[7:0];
          OP_ULP:
          begin
            mem_wa = eff(q.base, q.ir[7:0]);
            dev_viol = mem_wa < q.wlo || mem_wa > q.whi ||
                       mem[mem_wa][`DPRC_PROT_BIT]; // see [R13] [R14]
            if (dev_viol)
              ist_set[`DPRC_IST_PF1] = q.ien[`DPRC_IEN_PF1];
            else
            begin
              mem_we = 1'b1; // see [R15]
              mem_wd = {mem[mem_wa][`DPRC_PROT_BIT], 8'h00, q.p};
            end
          end
          OP_EXEC:
          begin
            // pointer word holds a section-relative target
            word = mem[eff(q.base, q.ir[7:0])];
            n.ir = mem[eff(q.base, word[7:0])][15:0]; // see [R6]
            n.xmode = 1'b1;
            n.st = ST_EXEC;
          end
          OP_CHRF:
          begin
            n.chvar = 1'b0;
            n.chsize = q.ir[`DPRC_INS_SIZE]; // see [R19]
            n.st = ST_CHAR;
          end
          OP_CHRV:
          begin
            n.chvar = 1'b1;
            n.st = ST_SPACE;
          end
          default: ;
        endcase
      end
      ST_SPACE:
      begin
        word = mem[eff(q.base, q.p)];
        n.spx = word[7:0]; // see [R20]
        n.spy = word[15:8];
        n.p = 8'(q.p + 8'h01);
        n.st = ST_CHAR;
      end
      ST_CHAR:
      begin
        // one character per word; a stop waits for the exit symbol
        word = mem[eff(q.base, q.p)];
        n.p = 8'(q.p + 8'h01);
        if (word[7:0] == `DPRC_CHAR_EXIT)
          n.st = ST_FETCH; // see [R19] [R20]
        else
        begin
          n.char_stb = 1'b1;
          n.char_code = word[7:0];
          if (q.chvar)
          begin
            n.bx = 16'(q.bx + {{8{q.spx[7]}}, q.spx}); // see [R20]
            n.by = 16'(q.by + {{8{q.spy[7]}}, q.spy});
          end
          else
          begin
            adv = q.chsize ? `DPRC_SPACE_B : `DPRC_SPACE_A;
            n.bx = 16'(q.bx + adv); // see [R19]
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // line-frequency clock interrupt
    n.rtc_on = rtc_en;
    if (!rtc_en)
      n.rtc_cnt = '0;
    else if (!q.rtc_on)
      n.rtc_cnt = RTC_FIRST_CYC[`DPRC_RTC_W-1:0]; // see [R3] [R16]
    else if (q.rtc_cnt == `DPRC_RTC_W'(1))
    begin
      ist_set[`DPRC_IST_RTC] = 1'b1;
      n.rtc_cnt = q.line50 ? RTC_P50_CYC[`DPRC_RTC_W-1:0]
                           : RTC_P60_CYC[`DPRC_RTC_W-1:0]; // see [R17]
    end
    else
      n.rtc_cnt = q.rtc_cnt - `DPRC_RTC_W'(1);
    // register writes and host function commands
    if (acc && pwrite_i)
    begin
      case (paddr_i)
        `DPRC_OFF_DATA: n.data = pwdata_i[15:0];
        `DPRC_OFF_CONFIG: n.line50 = pwdata_i[`DPRC_CFG_LINE50];
        `DPRC_OFF_CMD:
        begin
          case (cmd)
            C_RESET:
            begin
              n.ien = '0; // see [R1]
              n.st = ST_IDLE;
              n.stopreq = 1'b0;
              n.xmode = 1'b0;
            end
            C_LD_IEN:
              if (q.busy)
                rej = 1'b1; // see [R10]
              else
                n.ien = q.data; // see [R2] [R3]
            C_LD_IDIS:
              if (q.busy)
                rej = 1'b1; // see [R10]
              else
                n.ien = q.ien & ~q.data;
            C_UL_IEN: n.result = q.ien;
            C_LD_P, C_UL_P:
              if (q.busy)
                rej = 1'b1;
              else if (cmd == C_LD_P)
                n.p = q.data[7:0]; // see [R4]
              else
                n.result = {8'h00, q.p};
            C_LD_BASE, C_UL_BASE:
              if (q.busy)
                rej = 1'b1;
              else if (cmd == C_LD_BASE)
                n.base = q.data[7:0]; // see [R5]
              else
                n.result = {8'h00, q.base};
            C_START:
              if (q.busy)
                rej = 1'b1;
              else
                n.st = ST_FETCH; // see [R7]
            C_FINISH: n.stopreq = q.busy; // see [R11]
            C_LD_SCR, C_UL_SCR:
              if (q.busy)
                rej = 1'b1; // see [R8]
              else if (cmd == C_LD_SCR)
                n.scr[arg[3:0]] = q.data;
              else
                n.result = q.scr[arg[3:0]]; // see [R9]
            C_LD_WLIM:
              if (q.busy)
                rej = 1'b1;
              else
              begin
                n.wlo = q.data[7:0];
                n.whi = q.data[15:8];
              end
            // host writes would race the engine, so only when stopped
            C_LD_MEM, C_SET_PROT:
              if (q.busy)
                rej = 1'b1;
              else
              begin
                mem_we = 1'b1;
                mem_wa = arg;
                mem_wd = cmd == C_LD_MEM
                  ? {mem[arg][`DPRC_PROT_BIT], q.data}
                  : {q.data[0], mem[arg][15:0]};
              end
            C_UL_MEM: n.result = mem[arg][15:0];
            C_CLR_ISTAT: ist_clr = q.data[2:0];
            default: rej = 1'b1;
          endcase
          n.reply = !rej; // see [R21]
          n.reject = rej;
        end
        default: ;
      endcase
    end
    // a new event wins over a software clear
    n.istat = (q.istat & ~ist_clr) | ist_set;
    if (cmd_take && cmd == C_RESET)
      n.istat = '0; // see [R18]
    n.busy = n.st != ST_IDLE;
    n.irq = |q.istat;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.st <= ST_IDLE;
    end
    else
      q <= n;
  end

  // display memory, bit 16 is the protect bit; no reset needed
  always_ff @(posedge sys_clk_i)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign pready_o = q.pready;
  assign prdata_o = q.prdata;
  assign pslverr_o = q.pslverr;
  assign int_o = q.irq;
  assign running_o = q.busy;
  assign char_stb_o = q.char_stb;
  assign char_code_o = q.char_code;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_reset_ien;
    cmd_take && cmd == C_RESET |=> q.reply && q.ien == '0 && !q.busy;
  endproperty
  a_reset_ien: assert property (p_reset_ien) // see [R1]
    else $error("reset command did not clear enables");

  property p_load_ien;
    cmd_take && cmd == C_LD_IEN && !q.busy
      |=> q.reply && q.ien == $past(q.data);
  endproperty
  a_load_ien: assert property (p_load_ien) // see [R2]
    else $error("enable load not taken");

  property p_rtc_arm;
    $rose(rtc_en) |=> q.rtc_cnt == RTC_FIRST_CYC[`DPRC_RTC_W-1:0];
  endproperty
  a_rtc_arm: assert property (p_rtc_arm) // see [R3]
    else $error("clock interrupt not armed");

  property p_rtc_period;
    rtc_en && q.rtc_on && q.rtc_cnt == `DPRC_RTC_W'(1) &&
      !(cmd_take && cmd == C_RESET)
      |=> q.istat[`DPRC_IST_RTC] &&
          q.rtc_cnt == ($past(q.line50) ? RTC_P50_CYC[`DPRC_RTC_W-1:0]
                                        : RTC_P60_CYC[`DPRC_RTC_W-1:0]);
  endproperty
  a_rtc_period: assert property (p_rtc_period) // see [R17]
    else $error("clock interrupt period wrong");

  property p_unload_p;
    cmd_take && cmd == C_UL_P && !q.busy
      |=> q.reply && q.result[7:0] == q.p;
  endproperty
  a_unload_p: assert property (p_unload_p) // see [R4]
    else $error("pointer unload mismatch");

  property p_start;
    cmd_take && cmd == C_START && !q.busy
      |=> q.reply && q.st == ST_FETCH ##1 q.st == ST_EXEC;
  endproperty
  a_start: assert property (p_start) // see [R7]
    else $error("start did not begin fetching");

  property p_scr_rej;
    cmd_take && q.busy && (cmd == C_LD_SCR || cmd == C_UL_SCR)
      |=> q.reject && !q.reply && $stable(q.scr);
  endproperty
  a_scr_rej: assert property (p_scr_rej) // see [R8]
    else $error("scratchpad access not rejected");

  property p_ien_rej;
    cmd_take && q.busy && (cmd == C_LD_IEN || cmd == C_LD_IDIS)
      |=> q.reject && $stable(q.ien);
  endproperty
  a_ien_rej: assert property (p_ien_rej) // see [R10]
    else $error("enable load not rejected");

  property p_blocked;
    dev_viol |-> !mem_we ##1
      (q.istat[`DPRC_IST_PF1] || !$past(q.ien[`DPRC_IEN_PF1]));
  endproperty
  a_blocked: assert property (p_blocked) // see [R15]
    else $error("blocked write went through");

  property p_answer;
    cmd_take |=> q.reply != q.reject;
  endproperty
  a_answer: assert property (p_answer) // see [R21]
    else $error("command without single answer");

  property p_finish;
    q.stopreq && q.st == ST_FETCH |=> q.st == ST_IDLE && !q.busy;
  endproperty
  a_finish: assert property (p_finish) // see [R11]
    else $error("finish did not halt");

  c_start: cover property (cmd_take && cmd == C_START && !q.busy);
  c_pf1: cover property (dev_viol && q.ien[`DPRC_IEN_PF1]);
  c_rtc: cover property (ist_set[`DPRC_IST_RTC]);
  c_char: cover property (q.char_stb);
endmodule
`default_nettype wire

// >>> dv/dprc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dprc_host_model (
  input wire logic clk_i, // system clock
  input wire logic pready_i, // apb ready
  input wire logic [31:0] prdata_i, // apb read data
  input wire logic pslverr_i, // apb error
  output logic psel_o, // apb select
  output logic penable_o, // apb enable
  output logic pwrite_o, // apb write
  output logic [7:0] paddr_o, // apb address
  output logic [31:0] pwdata_o // apb write data
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'hFF;
    pwdata_o = 32'hFFFFFFFF;
  end

  // one transfer at a time, caller waits for the answer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e, output logic to);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_i !== 1'b1 && n < 16);
    r = prdata_i;
    e = pslverr_i;
    to = (n >= 16);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines show the inverse, never a stale match
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> dv/dprc_display_processor_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dprc_display_processor_bench;
  import dprc_pkg::*;
  localparam int FIRST = 20;
  localparam int P60 = 30;
  localparam int P50 = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, running, cstb;
  logic [7:0] paddr, ccode, last_code;
  logic [31:0] pwdata, prdata, rv;
  logic err;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int nchar = 0;

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cstb === 1'b1)
    begin
      nchar++;
      last_code = ccode;
    end
  end

  dprc_host_model i_host (.clk_i(clk), .pready_i(pready),
    .prdata_i(prdata), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));

  dprc_display_processor #(.RTC_FIRST_CYC(FIRST), .RTC_P60_CYC(P60),
    .RTC_P50_CYC(P50)) i_dut (.sys_clk_i(clk), .reset_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .int_o(irq),
    .running_o(running), .char_stb_o(cstb), .char_code_o(ccode));

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    logic to;
    i_host.xfer(w, a, d, rv, err, to);
    chk("apb answer in time", 0, to);
  endtask

  // ans 1 = reply, 2 = external reject
  task automatic cmd(logic [4:0] c, logic [7:0] arg, logic [15:0] d,
                     logic [1:0] ans);
    acc(1'b1, 8'h04, {16'h0000, d});
    acc(1'b1, 8'h00, {16'h0000, arg, 3'b000, c});
    acc(1'b0, 8'h08, 32'h0);
    chk("answer", ans, rv[1:0]);
  endtask

  task automatic unl(logic [4:0] c, logic [7:0] arg, logic [15:0] exp);
    cmd(c, arg, 16'h0000, 2'h1);
    acc(1'b0, 8'h0C, 32'h0);
    chk("unload data", exp, rv[15:0]);
  endtask

  task automatic run(logic [7:0] p);
    int n;
    cmd(C_LD_P, 8'h00, {8'h00, p}, 2'h1);
    cmd(C_START, 8'h00, 16'h0000, 2'h1);
    chk("running", 1, running);
    repeat (12) @(posedge clk);
    cmd(C_FINISH, 8'h00, 16'h0000, 2'h1);
    n = 0;
    while (running !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk("halted", 0, running);
  endtask

  task automatic t_regs;
    cmd(C_RESET, 8'h00, 16'h0000, 2'h1);
    unl(C_UL_IEN, 8'h00, 16'h0000);
    cmd(C_LD_IEN, 8'h00, 16'hEE8F, 2'h1);
    unl(C_UL_IEN, 8'h00, 16'hEE8F);
    cmd(C_LD_P, 8'h00, 16'h0034, 2'h1);
    unl(C_UL_P, 8'h00, 16'h0034);
    cmd(C_LD_BASE, 8'h00, 16'h0056, 2'h1);
    unl(C_UL_BASE, 8'h00, 16'h0056);
    cmd(C_LD_BASE, 8'h00, 16'h0000, 2'h1);
    acc(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 1, err);
    $display("test regs done");
  endtask

  task automatic t_run;
    logic [7:0] ma[22] = '{8'h10, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h28, 8'h29, 8'h2A, 8'h2C, 8'h30, 8'h31, 8'h40, 8'h60,
      8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67};
    logic [15:0] md[22] = '{16'h2010, 16'h1000, 16'h2021, 16'h4026,
      16'h2025, 16'h0027, 16'h0000, 16'h402A, 16'h2029, 16'h002C,
      16'h1000, 16'h3040, 16'h2031, 16'h1234, 16'h5000, 16'h0041,
      16'h0000, 16'h2063, 16'h5100, 16'h0044, 16'h0000, 16'h2067};
    foreach (ma[i]) cmd(C_LD_MEM, ma[i], md[i], 2'h1);
    cmd(C_LD_P, 8'h00, 16'h0010, 2'h1);
    cmd(C_START, 8'h00, 16'h0000, 2'h1);
    for (int s = 15; s >= 1; s--)
    begin
      cmd(C_LD_SCR, 8'(s), 16'h0001, 2'h2);
      cmd(C_UL_SCR, 8'(s), 16'h0000, 2'h2);
    end
    cmd(C_LD_IEN, 8'h00, 16'hEE8F, 2'h2);
    cmd(C_LD_IDIS, 8'h00, 16'h0001, 2'h2);
    cmd(C_RESET, 8'h00, 16'h0000, 2'h1);
    // rejected loads must not have reached the scratchpad
    for (int s = 15; s >= 1; s--)
      unl(C_UL_SCR, 8'(s), 16'h0000);
    cmd(C_LD_IEN, 8'h00, 16'hEE8F, 2'h1);
    run(8'h10);
    cmd(C_LD_IEN, 8'h00, 16'hEE8F, 2'h1);
    $display("test run done");
  endtask

  task automatic t_events;
    cmd(C_CLR_ISTAT, 8'h00, 16'h0007, 2'h1);
    run(8'h24);
    acc(1'b0, 8'h10, 32'h0);
    chk("control word no effect", 0, rv[2:0]);
    run(8'h28);
    acc(1'b0, 8'h10, 32'h0);
    chk("indirect eof", 1, rv[0]);
    cmd(C_CLR_ISTAT, 8'h00, 16'h0007, 2'h1);
    run(8'h20);
    acc(1'b0, 8'h10, 32'h0);
    chk("eof status", 1, rv[0]);
    chk("eof int", 1, irq);
    cmd(C_CLR_ISTAT, 8'h00, 16'h0007, 2'h1);
    cmd(C_LD_WLIM, 8'h00, 16'h6050, 2'h1);
    cmd(C_SET_PROT, 8'h40, 16'h0000, 2'h1);
    run(8'h30);
    acc(1'b0, 8'h10, 32'h0);
    chk("limit failure", 2, rv[1:0]);
    unl(C_UL_MEM, 8'h40, 16'h1234);
    cmd(C_CLR_ISTAT, 8'h00, 16'h0007, 2'h1);
    cmd(C_LD_WLIM, 8'h00, 16'hFF00, 2'h1);
    cmd(C_SET_PROT, 8'h40, 16'h0001, 2'h1);
    run(8'h30);
    acc(1'b0, 8'h10, 32'h0);
    chk("protect failure", 2, rv[1:0]);
    unl(C_UL_MEM, 8'h40, 16'h1234);
    $display("test events done");
  endtask

  task automatic chars(logic [7:0] p, logic [15:0] dx, logic [15:0] dy,
                       logic [7:0] code, int cnt);
    logic [15:0] x0, y0;
    int n0;
    acc(1'b0, 8'h18, 32'h0);
    x0 = rv[15:0];
    y0 = rv[31:16];
    n0 = nchar;
    run(p);
    acc(1'b0, 8'h18, 32'h0);
    chk("beam advance x", dx, 16'(rv[15:0] - x0));
    chk("beam advance y", dy, 16'(rv[31:16] - y0));
    chk("char count", cnt, nchar - n0);
    chk("char code", code, last_code);
  endtask

  logic [15:0] md_v[6] = '{16'h6000, 16'hF00F, 16'h0042, 16'h0043,
    16'h0000, 16'h206D};

  task automatic t_chars;
    chars(8'h60, 16'h0008, 16'h0000, 8'h41, 1);
    chars(8'h64, 16'h000C, 16'h0000, 8'h44, 1);
    foreach (md_v[i]) cmd(C_LD_MEM, 8'(8'h68 + i), md_v[i], 2'h1);
    // spacing 0F on x and F0 (minus 16) on y, two characters
    chars(8'h68, 16'h001E, 16'hFFE0, 8'h43, 2);
    $display("test chars done");
  endtask

  task automatic wait_int(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic rtc_per(int exp);
    int n, t0;
    // measure from one rise of the interrupt to the next
    cmd(C_CLR_ISTAT, 8'h00, 16'h0004, 2'h1);
    wait_int(n);
    t0 = cyc;
    cmd(C_CLR_ISTAT, 8'h00, 16'h0004, 2'h1);
    wait_int(n);
    chk("clock period", 1, (cyc - t0 >= exp - 2 && cyc - t0 <= exp + 2));
  endtask

  task automatic t_rtc;
    int n;
    cmd(C_RESET, 8'h00, 16'h0000, 2'h1);
    acc(1'b1, 8'h14, 32'h0);
    cmd(C_LD_IEN, 8'h00, 16'hFF8F, 2'h1);
    wait_int(n);
    // three cycles of the answer read already passed before counting
    chk("first clock int", 1, n + 3 <= FIRST + 3);
    unl(C_UL_IEN, 8'h00, 16'hFF8F);
    rtc_per(P60);
    acc(1'b1, 8'h14, 32'h1);
    rtc_per(P50);
    cmd(C_RESET, 8'h00, 16'h0000, 2'h1);
    acc(1'b0, 8'h10, 32'h0);
    chk("clock cleared", 0, rv[2]);
    $display("test rtc done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_run();
    t_events();
    t_chars();
    t_rtc();
    test_done();
  end

  // sized well past the longest path through all tests
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
